// ==== acc_pkg.sv ====
// acc_pkg: register map, field positions, reset values and bus carriers
// for the analog comparator control block; assumes a 32-bit AXI4-Lite bus.
package acc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses)
    localparam logic [7:0] ACC_OFF_CTRL = 8'h00;
    localparam logic [7:0] ACC_OFF_IRQ_MASK = 8'h04;

    ////////////////////////////////////////////////////////////////////////
    // field positions of comparator_status_control
    localparam int ACC_BIT_ENABLE = 7;
    localparam int ACC_BIT_REFSEL = 6;
    localparam int ACC_BIT_FLAG = 5;
    localparam int ACC_BIT_IRQEN = 4;
    localparam int ACC_BIT_OUTVAL = 3;
    localparam int ACC_BIT_PINEN = 2;
    localparam int ACC_BIT_MODE_HI = 1;
    localparam int ACC_BIT_MODE_LO = 0;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
    localparam logic ACC_MASK_RESET = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // bus answers
    localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // event modes
    typedef enum logic [1:0] {
        ACC_MODE_FALL0 = 2'b00,
        ACC_MODE_RISE = 2'b01,
        ACC_MODE_FALL2 = 2'b10,
        ACC_MODE_BOTH = 2'b11
    } acc_mode_t;

    // control fields held by software
    typedef struct packed {
        logic enable;
        logic refSel;
        logic irqEn;
        logic pinEn;
        acc_mode_t mode;
    } acc_ctrl_t;

    // analog-side signals leaving the block
    typedef struct packed {
        logic moduleEnable;
        logic refSel;
    } acc_analog_t;

endpackage

// ==== acc_edge_detect.sv ====
// acc_edge_detect: two-stage synchroniser and edge event on the raw
// comparator result; assumes the result is asynchronous to clk.
module acc_edge_detect
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // control
    input wire logic enable,
    input acc_mode_t mode,
    // comparator side
    input wire logic cmpRaw,
    // results
    output logic level,
    output logic event_
);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    wire rise = sync2_q & ~prev_q;
    wire fall = ~sync2_q & prev_q;

    ////////////////////////////////////////////////////////////////////////
    // synchroniser; held at zero while disabled
    always_ff @(posedge clk) begin
        if (!rstn || (ce && !enable)) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (ce) begin
            sync1_q <= cmpRaw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event select
    always_comb begin
        case (mode)
            ACC_MODE_FALL0: event_ = fall;
            ACC_MODE_RISE: event_ = rise;
            ACC_MODE_FALL2: event_ = fall;
            ACC_MODE_BOTH: event_ = rise | fall;
            default: event_ = 1'b0;
        endcase
    end

    assign level = sync2_q;

endmodule // acc_edge_detect

// ==== acc_top.sv ====
// acc_top: analog comparator control register, event flag and interrupt
// behind an AXI4-Lite slave; assumes the analog core gives a raw level.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
module acc_top
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // power state
    input wire logic deepStopWake,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog core
    input wire logic cmpResult,
    output acc_analog_t analogCtrl,
    output logic invertingToCore,
    // output pin, enable active low
    output logic cmpPinOut,
    output logic cmpPinOe_n,
    // interrupt and wake
    output logic irq,
    output logic wakeReq
);

    ////////////////////////////////////////////////////////////////////////
    // state
    acc_ctrl_t ctrl_q;
    logic flag_q;
    logic mask_q;
    logic [7:0] awaddr_q;
    logic awHave_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wHave_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic pinOut_q;
    logic pinOe_n_q;

    wire syncRst = !rstn || deepStopWake;
    wire level;
    wire cmpEvent;

    acc_edge_detect u_edge (
        .clk(clk),
        .rstn(!syncRst),
        .ce(ce),
        .enable(ctrl_q.enable),
        .mode(ctrl_q.mode),
        .cmpRaw(cmpResult),
        .level(level),
        .event_(cmpEvent)
    );

    ////////////////////////////////////////////////////////////////////////
    // register image
    function automatic logic [7:0] ctrl_image(acc_ctrl_t c, logic f, logic lv);
        logic [7:0] v;
        v = 8'h00;
        v[ACC_BIT_ENABLE] = c.enable;
        v[ACC_BIT_REFSEL] = c.refSel;
        v[ACC_BIT_FLAG] = f;
        v[ACC_BIT_IRQEN] = c.irqEn;
        v[ACC_BIT_OUTVAL] = lv & c.enable;
        v[ACC_BIT_PINEN] = c.pinEn;
        v[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO] = c.mode;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control fields from a written byte
    function automatic acc_ctrl_t ctrl_decode(logic [7:0] w);
        acc_ctrl_t c;
        c.enable = w[ACC_BIT_ENABLE];
        c.refSel = w[ACC_BIT_REFSEL];
        c.irqEn = w[ACC_BIT_IRQEN];
        c.pinEn = w[ACC_BIT_PINEN];
        c.mode = acc_mode_t'(w[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO]);
        return c;
    endfunction

    // word select: only the word part of a byte address takes part
    function automatic logic reg_sel(logic [7:0] addr, logic [7:0] off);
        return addr[7:2] == off[7:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write decode
    wire wrFire = awHave_q && wHave_q && !bvalid_q;
    wire wrHitCtrl = reg_sel(awaddr_q, ACC_OFF_CTRL);
    wire wrHitMask = reg_sel(awaddr_q, ACC_OFF_IRQ_MASK);
    wire wrCtrl = wrFire && wrHitCtrl && wstrb_q[0];
    wire wrMask = wrFire && wrHitMask && wstrb_q[0];
    wire wrHit = wrHitCtrl || wrHitMask;
    wire flagClr = wrCtrl && wdata_q[ACC_BIT_FLAG];
    wire flagSet = cmpEvent && ctrl_q.enable;
    wire [7:0] ctrlImg = ctrl_image(ctrl_q, flag_q, level);

    ////////////////////////////////////////////////////////////////////////
    // read decode
    wire rdFire = s_axi_arvalid && !rvalid_q;
    wire rdCtrl = reg_sel(s_axi_araddr, ACC_OFF_CTRL);
    wire rdMask = reg_sel(s_axi_araddr, ACC_OFF_IRQ_MASK);
    wire [31:0] rdWord = rdCtrl ? {24'h000000, ctrlImg}
        : rdMask ? {31'h00000000, mask_q} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // write address holding; taking and firing never meet in one cycle
    always_ff @(posedge clk) begin
        if (syncRst) begin
            awHave_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wrFire) begin
                awHave_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write data holding
    always_ff @(posedge clk) begin
        if (syncRst) begin
            wHave_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wrFire) begin
                wHave_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write response
    always_ff @(posedge clk) begin
        if (syncRst) begin
            bvalid_q <= 1'b0;
            bresp_q <= ACC_RESP_OKAY;
        end else if (ce) begin
            if (wrFire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wrHit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel
    always_ff @(posedge clk) begin
        if (syncRst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= ACC_RESP_OKAY;
        end else if (ce) begin
            if (rdFire) begin
                rvalid_q <= 1'b1;
                rdata_q <= rdWord;
                rresp_q <= (rdCtrl || rdMask) ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge clk) begin
        if (syncRst) begin
            ctrl_q <= ctrl_decode(ACC_CTRL_RESET);
        end else if (ce && wrCtrl) begin
            ctrl_q <= ctrl_decode(wdata_q[7:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt mask
    always_ff @(posedge clk) begin
        if (syncRst) begin
            mask_q <= ACC_MASK_RESET;
        end else if (ce && wrMask) begin
            mask_q <= wdata_q[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event flag; a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (syncRst) begin
            flag_q <= ACC_CTRL_RESET[ACC_BIT_FLAG];
        end else if (ce) begin
            if (flagSet) begin
                flag_q <= 1'b1;
            end else if (flagClr) begin
                flag_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pin
    always_ff @(posedge clk) begin
        if (syncRst) begin
            pinOut_q <= 1'b0;
            pinOe_n_q <= 1'b1;
        end else if (ce) begin
            pinOut_q <= level & ctrl_q.enable & ctrl_q.pinEn;
            pinOe_n_q <= !(ctrl_q.enable && ctrl_q.pinEn);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready = !awHave_q && !bvalid_q;
    assign s_axi_wready = !wHave_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign analogCtrl.moduleEnable = ctrl_q.enable;
    assign analogCtrl.refSel = ctrl_q.refSel;
    assign invertingToCore = 1'b1;
    assign cmpPinOut = pinOut_q;
    assign cmpPinOe_n = pinOe_n_q;
    assign irq = ctrl_q.irqEn && flag_q && mask_q;
    assign wakeReq = ctrl_q.irqEn && flag_q;

endmodule // acc_top

// ==== acc_top_assertions.sv ====
// acc_top_assertions: port checks for acc_top
// assumes one clock domain and ce held high
module acc_top_assertions
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic deepStopWake,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    // analog side and pins
    input wire logic cmpResult,
    input acc_analog_t analogCtrl,
    input wire logic invertingToCore,
    input wire logic cmpPinOut,
    input wire logic cmpPinOe_n,
    input wire logic irq,
    input wire logic wakeReq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn || deepStopWake);
    ////////////////////////////////////////
    a_reset_idle: assert property (disable iff (1'b0)
        (!rstn || deepStopWake) |=> !irq && !s_axi_bvalid && !s_axi_rvalid
        && cmpPinOe_n && analogCtrl == 2'b00) else $error("state not idle after reset");
    a_oe_needs_enable: assert property (!cmpPinOe_n |-> $past(analogCtrl.moduleEnable))
        else $error("pin driven while disabled");
    a_pin_quiet: assert property (cmpPinOe_n |-> !cmpPinOut)
        else $error("pin level while not driven");
    a_pin_result: assert property (($stable(cmpResult) && !cmpPinOe_n)[*5]
        |-> cmpPinOut == cmpResult) else $error("pin not following result");
    a_inv_tied: assert property (invertingToCore)
        else $error("inverting input detached");
    a_irq_wakes: assert property (irq |-> wakeReq)
        else $error("interrupt without wake");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    c_irq: cover property ($rose(irq));
    c_pin: cover property ($fell(cmpPinOe_n));
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // acc_top_assertions

bind acc_top acc_top_assertions u_acc_top_assertions (.clk, .rstn, .deepStopWake,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .cmpResult, .analogCtrl,
    .invertingToCore, .cmpPinOut, .cmpPinOe_n, .irq, .wakeReq);

// ==== acc_cmp_model.sv ====
// acc_cmp_model: behavioural comparator core and its analog pins
// assumes levels in millivolts and a fixed internal reference
module acc_cmp_model
    import acc_pkg::*;
#(
    parameter logic [11:0] REF_MV = 12'h0c8
) (
    // analog pins
    input wire logic [11:0] plusMv,
    input wire logic [11:0] minusMv,
    // control from the block
    input acc_analog_t analogCtrl,
    input wire logic invertingToCore,
    // result
    output logic cmpResult
);
    logic [11:0] nonInv;
    assign nonInv = analogCtrl.refSel ? REF_MV : plusMv;
    // a powered-down core gives a low result
    assign cmpResult = analogCtrl.moduleEnable && invertingToCore
        && (nonInv > minusMv);
endmodule // acc_cmp_model

// ==== acc_top_bench.sv ====
// acc_top_bench: self-checking bench for acc_top with the comparator model
// assumes ce held high and full byte strobes on every write
module acc_top_bench
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, deepStopWake = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic cmpResult, invertingToCore, cmpPinOut, cmpPinOe_n, irq, wakeReq;
    acc_analog_t analogCtrl;
    logic [11:0] minusMv = 12'h096;
    int miscompares = 0;
    int tests_run = 0;
    always #12.5 clk = ~clk;
    acc_top u_acc_top (.clk, .rstn, .ce, .deepStopWake, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cmpResult, .analogCtrl, .invertingToCore, .cmpPinOut, .cmpPinOe_n, .irq, .wakeReq);
    acc_cmp_model u_acc_cmp_model (.plusMv(12'h064), .minusMv, .analogCtrl,
        .invertingToCore, .cmpResult);
    ////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task conclude;
        $display("%0d compared, %0d mismatches", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task cmpTo(input logic hi);
        @(posedge clk);
        minusMv <= hi ? 12'h032 : 12'h096;
        repeat (5) @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic ga, gw, gb;
        logic [1:0] er;
        int n;
        er = (a == ACC_OFF_CTRL || a == ACC_OFF_IRQ_MASK) ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            ga = s_axi_awvalid & s_axi_awready;
            gw = s_axi_wvalid & s_axi_wready;
            gb = s_axi_bvalid;
            if (gb) chk(s_axi_bresp, er, "write response");
            @(posedge clk);
            if (ga) s_axi_awvalid <= 1'b0;
            if (gw) s_axi_wvalid <= 1'b0;
            if (gb) break;
        end
        s_axi_bready <= 1'b0;
        chk(n < 40, 1'b1, "write timeout");
        if (n == 40) conclude();
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        logic ga, gb;
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            ga = s_axi_arvalid & s_axi_arready;
            gb = s_axi_rvalid;
            if (gb) chk(s_axi_rdata, e, "read data");
            if (gb) chk(s_axi_rresp, r, "read response");
            @(posedge clk);
            if (ga) s_axi_arvalid <= 1'b0;
            if (gb) break;
        end
        s_axi_rready <= 1'b0;
        chk(n < 40, 1'b1, "read timeout");
        if (n == 40) conclude();
    endtask
    ////////////////////////////////////////
    task tReset;
        rdc(ACC_OFF_CTRL, ACC_CTRL_RESET, ACC_RESP_OKAY);
        rdc(ACC_OFF_IRQ_MASK, ACC_MASK_RESET, ACC_RESP_OKAY);
        rdc(8'h08, 32'h0, ACC_RESP_SLVERR);
        wr(8'h08, 8'hff);
        rdc(ACC_OFF_CTRL, ACC_CTRL_RESET, ACC_RESP_OKAY);
        $display("test reset done");
    endtask
    task tModes;
        logic [7:0] c;
        for (int m = 0; m < 4; m++) begin
            c = 8'h80 | m[7:0];
            cmpTo(1'b0);
            wr(ACC_OFF_CTRL, c | 8'h20);
            cmpTo(1'b1);
            rdc(ACC_OFF_CTRL, c | 8'h08 | (m[0] ? 8'h20 : 8'h00), 2'h0);
            wr(ACC_OFF_CTRL, c | 8'h20);
            cmpTo(1'b0);
            wr(ACC_OFF_CTRL, c);
            rdc(ACC_OFF_CTRL, c | (m != 1 ? 8'h20 : 8'h00), 2'h0);
        end
        wr(ACC_OFF_CTRL, 8'h20);
        $display("test modes done");
    endtask
    task tRef;
        wr(ACC_OFF_CTRL, 8'hc0);
        chk(analogCtrl, 2'b11, "core control");
        repeat (4) @(posedge clk);
        rdc(ACC_OFF_CTRL, 32'hc8, ACC_RESP_OKAY);
        wr(ACC_OFF_CTRL, 8'h80);
        repeat (4) @(posedge clk);
        rdc(ACC_OFF_CTRL, 32'ha0, ACC_RESP_OKAY);
        cmpTo(1'b1);
        wr(ACC_OFF_CTRL, 8'h20);
        rdc(ACC_OFF_CTRL, 32'h00, ACC_RESP_OKAY);
        $display("test reference done");
    endtask
    task tIrq;
        wr(ACC_OFF_CTRL, 8'h90);
        cmpTo(1'b0);
        chk(irq, 1'b1, "irq on");
        chk(wakeReq, 1'b1, "wake on");
        wr(ACC_OFF_IRQ_MASK, 8'h00);
        chk(irq, 1'b0, "irq masked");
        wr(ACC_OFF_IRQ_MASK, 8'h01);
        wr(ACC_OFF_CTRL, 8'h80);
        chk(irq, 1'b0, "irq disabled");
        wr(ACC_OFF_CTRL, 8'hb0);
        chk(irq, 1'b0, "irq cleared");
        $display("test interrupt done");
    endtask
    task tPin;
        wr(ACC_OFF_CTRL, 8'h84);
        cmpTo(1'b1);
        chk(cmpPinOe_n, 1'b0, "pin driven");
        chk(cmpPinOut, 1'b1, "pin high");
        chk(analogCtrl.moduleEnable, 1'b1, "core on");
        cmpTo(1'b0);
        chk(cmpPinOut, 1'b0, "pin low");
        wr(ACC_OFF_CTRL, 8'h00);
        @(negedge clk);
        chk(cmpPinOe_n, 1'b1, "pin released");
        chk(analogCtrl.moduleEnable, 1'b0, "core off");
        $display("test pin done");
    endtask
    task tDeep;
        wr(ACC_OFF_IRQ_MASK, 8'h00);
        wr(ACC_OFF_CTRL, 8'hd4);
        @(posedge clk);
        deepStopWake <= 1'b1;
        @(posedge clk);
        deepStopWake <= 1'b0;
        rdc(ACC_OFF_CTRL, 32'h00, ACC_RESP_OKAY);
        rdc(ACC_OFF_IRQ_MASK, 32'h01, ACC_RESP_OKAY);
        $display("test deep stop done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        tReset();
        tModes();
        tRef();
        tIrq();
        tPin();
        tDeep();
        conclude();
    end
endmodule // acc_top_bench
